//--- core/mdcp_core.sv
`timescale 1ns/1ns
// Functional notes
// RL1 - Every command gets exactly one reply
// RL2 - Bytes one at a time, low byte first
// RL3 - Seven-bit opcodes, sixteen-bit data words
// RL4 - Unknown command: send NACK, do nothing else
// RL5 - 0x30 powers down, acknowledges with 0x2E
// RL6 - Freeze, channels to midscale, bias off, ACK
// RL7 - 0x31 applies bias, ramps frame, ACK
// RL8 - Standby holds midscale with zero bias
// RL9 - 0x56 sends 961-byte voltage packet
// RL10 - Empty slots report midscale 0x8000
// RL11 - Readback is offset binary, 32768 zero
// RL12 - 0x53 sends 297-byte status packet
// RL13 - Condition bits 0-4: ready..factory mode
// RL14 - Bits 5-7: amps off, settled, bad command
// RL15 - Upper byte holds fault flags
// RL16 - Bit 14 flags channel near rail
// RL17 - Presence word: bits 0-5 zero, cards
// RL18 - Deep or long bias sag forces shutdown; code trips only on a deep sag held RESERVE_CNT cycles
// RL19 - Rail collapse beyond reserve disables driver
// RL20 - Latch-up fault sensed forces shutdown
// RL21 - NACK character is 0x3F
// RL22 - Per-card table holds fourteen words
// RL23 - Switch word upper byte: address switches
// RL24 - Finish one reply before next command
// RL25 - Host waits for ACK before unplugging
module mdcp_core
	import mdcp_pkg::*;
#(
	parameter int RESERVE_CNT = RESERVE_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Received characters
	input  wire logic        rx_valid,
	output logic             rx_ready,
	input  wire logic [7:0]  rx_data,
	// Transmitted characters
	output logic             tx_valid,
	input  wire logic        tx_ready,
	output logic      [7:0]  tx_data,
	// Data source for packets
	output logic             rd_req,
	output logic             rd_volt,
	output logic      [8:0]  rd_index,
	input  wire logic        rd_ack,
	input  wire logic [15:0] rd_word,
	// Status sources
	input  wire logic [9:0]  card_present,
	input  wire logic [15:0] bias_value,
	input  wire logic [15:0] aux_bias_value,
	input  wire logic [15:0] rail24_value,
	input  wire logic [15:0] backplane_temp,
	input  wire logic [15:0] fan_count,
	input  wire logic [7:0]  option_switches,
	input  wire logic [7:0]  address_switches,
	input  wire logic        input_port_live,
	input  wire logic        diagnostic_mode_flag,
	input  wire logic        factory_mode_flag,
	input  wire logic        reference_settled,
	input  wire logic        board_layout_fault,
	input  wire logic        rail_tolerance_flag,
	input  wire logic        too_hot_flag,
	input  wire logic        hardware_fault_flag,
	input  wire logic        cooling_loss_flag,
	input  wire logic        slew_idle_flag,
	input  wire logic        bias_sag_deep,
	input  wire logic        rail_collapse,
	input  wire logic        latchup_sense,
	input  wire logic        headroom_sample_valid,
	input  wire logic [15:0] headroom_sample,
	// Ramp control toward the analog side
	output logic             frame_freeze,
	output logic             chan_ramp_req,
	output logic             chan_to_mid,
	input  wire logic        chan_ramp_done,
	output logic             bias_ramp_req,
	output logic             bias_on_target,
	input  wire logic        bias_ramp_done,
	output logic             amps_shut_down,
	output logic [15:0]      controller_condition_word,
	output logic [15:0]      card_presence_word
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] pin_s1_q, pin_s2_q;
	logic       sag_s, coll_s, latch_s;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pin_s1_q <= 3'b000;
			pin_s2_q <= 3'b000;
		end else begin
			pin_s1_q <= {latchup_sense, rail_collapse, bias_sag_deep};
			pin_s2_q <= pin_s1_q;
		end
	end
	assign sag_s   = pin_s2_q[0];
	assign coll_s  = pin_s2_q[1];
	assign latch_s = pin_s2_q[2];

	// ----------------------------------------
	// Output byte buffer
	// ----------------------------------------
	logic       ob_valid, ob_ready;
	logic [7:0] ob_data;

	mdcp_skid #(.W(8)) u_skid (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (ob_valid),
		.in_ready  (ob_ready),
		.in_data   (ob_data),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  (tx_data)
	);

	function automatic logic near_rail(input logic [15:0] v);
		return (v >= HEADROOM_HI) || (v <= HEADROOM_LO);
	endfunction

	// ----------------------------------------
	// Fault supervision
	// ----------------------------------------
	logic [$clog2(RESERVE_CNT+1)-1:0] coll_cnt_q, coll_cnt_d;
	logic [$clog2(RESERVE_CNT+1)-1:0] sag_cnt_q, sag_cnt_d;
	logic fault_trip;
	logic headroom_q, headroom_d;

	always_comb begin
		coll_cnt_d = coll_s ? coll_cnt_q : '0;
		sag_cnt_d  = sag_s ? sag_cnt_q : '0;
		if (coll_s && coll_cnt_q != RESERVE_CNT[$bits(coll_cnt_q)-1:0])
			coll_cnt_d = coll_cnt_q + 1'b1;                 // [RL19]
		if (sag_s && sag_cnt_q != RESERVE_CNT[$bits(sag_cnt_q)-1:0])
			sag_cnt_d = sag_cnt_q + 1'b1;                   // [RL18]
		headroom_d = headroom_q;
		if (headroom_sample_valid)
			headroom_d = near_rail(headroom_sample);    // [RL16] [RL11]
	end

	assign fault_trip =
		(coll_cnt_q == RESERVE_CNT[$bits(coll_cnt_q)-1:0]) ||  // [RL19]
		(sag_cnt_q == RESERVE_CNT[$bits(sag_cnt_q)-1:0]) ||    // [RL18]
		latch_s;                                               // [RL20]

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			coll_cnt_q <= '0;
			sag_cnt_q  <= '0;
			headroom_q <= 1'b0;
		end else begin
			coll_cnt_q <= coll_cnt_d;
			sag_cnt_q  <= sag_cnt_d;
			headroom_q <= headroom_d;
		end
	end

	// ----------------------------------------
	// Command sequencer
	// ----------------------------------------
	mdcp_state_e state_q, state_d;
	logic        bias_q, bias_d;
	logic        shut_q, shut_d;
	logic        bad_q, bad_d;
	logic        freeze_q, freeze_d;
	logic        cramp_q, cramp_d, mid_q, mid_d;
	logic        bramp_q, bramp_d, btgt_q, btgt_d;
	logic        volt_q, volt_d;
	logic        hi_q, hi_d;
	logic [7:0]  pend_q, pend_d;
	logic [9:0]  bcnt_q, bcnt_d;
	logic [15:0] word_q, word_d;
	logic [8:0]  widx_q, widx_d;
	logic        req_q, req_d;
	logic [15:0] cond_w, pres_w;
	logic [9:0]  pkt_len;

	assign pres_w = {card_present, {CARD_LSB{1'b0}}};           // [RL17]
	always_comb begin
		cond_w              = '0;
		cond_w[CW_READY]    = (state_q == MDCP_IDLE) && !shut_q;  // [RL13]
		cond_w[CW_BIAS_ON]  = bias_q;
		cond_w[CW_INPUT]    = input_port_live;
		cond_w[CW_DIAG]     = diagnostic_mode_flag;
		cond_w[CW_FACTORY]  = factory_mode_flag;
		cond_w[CW_AMPS_OFF] = shut_q;                             // [RL14]
		cond_w[CW_REF_OK]   = reference_settled;
		cond_w[CW_BAD_CMD]  = bad_q;
		cond_w[CW_LAYOUT]   = board_layout_fault;                 // [RL15]
		cond_w[CW_RAIL]     = rail_tolerance_flag;
		cond_w[CW_REF_FLT]  = sag_cnt_q != '0 && sag_s;
		cond_w[CW_HOT]      = too_hot_flag;
		cond_w[CW_HW]       = hardware_fault_flag || latch_s;
		cond_w[CW_COOL]     = cooling_loss_flag;
		cond_w[CW_HEADROOM] = headroom_q;                         // [RL16]
		cond_w[CW_SLEW]     = slew_idle_flag || coll_s;
	end

	// Header words of the status packet, in order
	function automatic logic [15:0] hdr_word(input logic [8:0] i,
		input logic [15:0] c, input logic [15:0] p);
		unique case (i)
			9'd0: return c;
			9'd1: return p;
			9'd2: return bias_value;
			9'd3: return aux_bias_value;
			9'd4: return rail24_value;
			9'd5: return backplane_temp;
			9'd6: return fan_count;
			default: return {address_switches, option_switches}; // [RL23]
		endcase
	endfunction

	// Slot owning a word index, for empty slot substitution
	function automatic logic slot_empty(input logic [8:0] i);
		logic [3:0] s;
		s = 4'(i / CHAN_PER_SLOT);
		return (s < 4'(NUM_SLOTS)) ? !card_present[s] : 1'b1;
	endfunction

	always_comb begin
		state_d  = state_q;
		bias_d   = bias_q;
		shut_d   = shut_q;
		bad_d    = bad_q;
		freeze_d = freeze_q;
		cramp_d  = 1'b0;
		mid_d    = mid_q;
		bramp_d  = 1'b0;
		btgt_d   = btgt_q;
		volt_d   = volt_q;
		hi_d     = hi_q;
		pend_d   = pend_q;
		bcnt_d   = bcnt_q;
		word_d   = word_q;
		widx_d   = widx_q;
		req_d    = 1'b0;
		ob_valid = 1'b0;
		ob_data  = pend_q;
		rx_ready = (state_q == MDCP_IDLE);                        // [RL24]
		pkt_len  = volt_q ? 10'(VOLT_PKT_BYTES) : 10'(STAT_PKT_BYTES);
		unique case (state_q)
			MDCP_IDLE: begin
				if (rx_valid) begin
					unique case (rx_data[6:0])                    // [RL3]
						CMD_POWER_DOWN[6:0]: begin
							freeze_d = 1'b1;                      // [RL6]
							mid_d    = 1'b1;
							cramp_d  = 1'b1;
							state_d  = MDCP_DOWN;                 // [RL5]
						end
						CMD_POWER_UP[6:0]: begin
							btgt_d   = 1'b1;                      // [RL7]
							bramp_d  = 1'b1;
							state_d  = MDCP_UP;
						end
						CMD_VOLTAGE[6:0], CMD_STATUS[6:0]: begin
							volt_d  = (rx_data[6:0] == CMD_VOLTAGE[6:0]);
							pend_d  = rx_data;                    // [RL9] [RL12]
							bcnt_d  = '0;
							widx_d  = '0;
							hi_d    = 1'b0;
							state_d = MDCP_REPLY;
						end
						default: begin
							bad_d   = 1'b1;                       // [RL4]
							pend_d  = RSP_NACK;                   // [RL21]
							bcnt_d  = 10'd1;
							state_d = MDCP_SEND;
						end
					endcase
					if (rx_data[7]) begin
						bad_d   = 1'b1;                           // [RL4]
						pend_d  = RSP_NACK;
						bcnt_d  = 10'd1;
						freeze_d = freeze_q;
						mid_d   = mid_q;
						btgt_d  = btgt_q;
						cramp_d = 1'b0;
						bramp_d = 1'b0;
						state_d = MDCP_SEND;
					end
				end
			end
			MDCP_DOWN: begin
				if (chan_ramp_done && mid_q && !btgt_q) begin
					bias_d   = 1'b0;                              // [RL8]
					pend_d   = RSP_ACK;                           // [RL5]
					bcnt_d   = 10'd1;
					state_d  = MDCP_SEND;
				end else if (chan_ramp_done && btgt_q) begin
					btgt_d  = 1'b0;                               // [RL6]
					bramp_d = 1'b1;
				end else if (bias_ramp_done && !btgt_q) begin
					bias_d  = 1'b0;
					pend_d  = RSP_ACK;                            // [RL6]
					bcnt_d  = 10'd1;
					state_d = MDCP_SEND;
				end
			end
			MDCP_UP: begin
				if (bias_ramp_done) begin
					bias_d   = 1'b1;
					shut_d   = 1'b0;
					freeze_d = 1'b0;
					mid_d    = 1'b0;                              // [RL7]
					cramp_d  = 1'b1;
					pend_d   = RSP_ACK;
					bcnt_d   = 10'd1;
					state_d  = MDCP_SEND;
				end
			end
			MDCP_SEND: begin
				ob_valid = 1'b1;                                  // [RL1]
				if (ob_ready)
					state_d = MDCP_IDLE;
			end
			MDCP_REPLY: begin
				ob_valid = 1'b1;
				ob_data  = (bcnt_q == '0) ? pend_q :
				           (hi_q ? word_q[15:8] : word_q[7:0]);   // [RL2]
				if (bcnt_q == '0 && ob_ready) begin
					bcnt_d  = 10'd1;
					state_d = MDCP_FETCH;
				end else if (ob_ready) begin
					bcnt_d = bcnt_q + 10'd1;
					hi_d   = !hi_q;
					if (bcnt_q + 10'd1 == pkt_len)
						state_d = MDCP_IDLE;                      // [RL1]
					else if (hi_q)
						state_d = MDCP_FETCH;
				end
			end
			MDCP_FETCH: begin
				hi_d = 1'b0;
				if (!volt_q && widx_q < 9'(HDR_WORDS)) begin
					word_d  = hdr_word(widx_q, cond_w, pres_w);    // [RL12]
					widx_d  = widx_q + 9'd1;
					state_d = MDCP_REPLY;
				end else if (volt_q && slot_empty(widx_q)) begin
					word_d  = MIDSCALE;                           // [RL10]
					widx_d  = widx_q + 9'd1;
					state_d = MDCP_REPLY;
				end else if (rd_ack) begin
					word_d  = rd_word;                            // [RL22]
					widx_d  = widx_q + 9'd1;
					state_d = MDCP_REPLY;
				end else begin
					req_d = 1'b1;
				end
			end
			default: state_d = MDCP_IDLE;
		endcase
		if (fault_trip && !shut_q) begin
			shut_d   = 1'b1;                                  // [RL19] [RL20]
			bias_d   = 1'b0;
			freeze_d = 1'b1;
			mid_d    = 1'b1;
			btgt_d   = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q  <= MDCP_IDLE;
			bias_q   <= 1'b0;
			shut_q   <= 1'b0;
			bad_q    <= 1'b0;
			freeze_q <= 1'b0;
			cramp_q  <= 1'b0;
			mid_q    <= 1'b1;                                 // [RL8]
			bramp_q  <= 1'b0;
			btgt_q   <= 1'b0;
			volt_q   <= 1'b0;
			hi_q     <= 1'b0;
			pend_q   <= '0;
			bcnt_q   <= '0;
			word_q   <= '0;
			widx_q   <= '0;
			req_q    <= 1'b0;
		end else begin
			state_q  <= state_d;
			bias_q   <= bias_d;
			shut_q   <= shut_d;
			bad_q    <= bad_d;
			freeze_q <= freeze_d;
			cramp_q  <= cramp_d;
			mid_q    <= mid_d;
			bramp_q  <= bramp_d;
			btgt_q   <= btgt_d;
			volt_q   <= volt_d;
			hi_q     <= hi_d;
			pend_q   <= pend_d;
			bcnt_q   <= bcnt_d;
			word_q   <= word_d;
			widx_q   <= widx_d;
			req_q    <= req_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rd_req                    = req_q;
	assign rd_volt                   = volt_q;
	assign rd_index                  = widx_q - (volt_q ? 9'd0 : 9'(HDR_WORDS));
	assign frame_freeze              = freeze_q;
	assign chan_ramp_req             = cramp_q;
	assign chan_to_mid               = mid_q;
	assign bias_ramp_req             = bramp_q;
	assign bias_on_target            = btgt_q;
	assign amps_shut_down            = shut_q;
	assign controller_condition_word = cond_w;
	assign card_presence_word        = pres_w;

endmodule

//--- core/mdcp_pkg.sv
package mdcp_pkg;

	// ----------------------------------------
	// Command and response characters
	// ----------------------------------------
	localparam logic [7:0] CMD_POWER_DOWN = 8'h30;
	localparam logic [7:0] CMD_POWER_UP   = 8'h31;
	localparam logic [7:0] CMD_VOLTAGE    = 8'h56;
	localparam logic [7:0] CMD_STATUS     = 8'h53;
	localparam logic [7:0] RSP_ACK        = 8'h2E;
	localparam logic [7:0] RSP_NACK       = 8'h3F;

	// ----------------------------------------
	// Packet geometry
	// ----------------------------------------
	localparam int NUM_SLOTS        = 10;
	localparam int CHAN_PER_SLOT    = 48;
	localparam int WORDS_PER_DRV    = 14;
	localparam int HDR_WORDS        = 8;
	localparam int VOLT_PKT_BYTES   = 961;
	localparam int STAT_PKT_BYTES   = 297;
	localparam logic [15:0] MIDSCALE = 16'h8000;
	// Within twenty percent of half scale of either rail
	localparam logic [15:0] HEADROOM_HI = 16'hE666;
	localparam logic [15:0] HEADROOM_LO = 16'h199A;

	// ----------------------------------------
	// Controller condition word bit positions
	// ----------------------------------------
	localparam int CW_READY    = 0;
	localparam int CW_BIAS_ON  = 1;
	localparam int CW_INPUT    = 2;
	localparam int CW_DIAG     = 3;
	localparam int CW_FACTORY  = 4;
	localparam int CW_AMPS_OFF = 5;
	localparam int CW_REF_OK   = 6;
	localparam int CW_BAD_CMD  = 7;
	localparam int CW_LAYOUT   = 8;
	localparam int CW_RAIL     = 9;
	localparam int CW_REF_FLT  = 10;
	localparam int CW_HOT      = 11;
	localparam int CW_HW       = 12;
	localparam int CW_COOL     = 13;
	localparam int CW_HEADROOM = 14;
	localparam int CW_SLEW     = 15;
	localparam int CARD_LSB    = 6;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ         = 100;
	localparam int RESERVE_US      = 10;
	localparam int RESERVE_CYCLES  = RESERVE_US * CLK_MHZ;

	typedef enum logic [5:0] {
		MDCP_IDLE  = 6'b00_0001,
		MDCP_DOWN  = 6'b00_0010,
		MDCP_UP    = 6'b00_0100,
		MDCP_SEND  = 6'b00_1000,
		MDCP_REPLY = 6'b01_0000,
		MDCP_FETCH = 6'b10_0000
	} mdcp_state_e;

endpackage

//--- core/mdcp_skid.sv
`timescale 1ns/1ns
module mdcp_skid #(
	parameter int W = 8
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);

	// ----------------------------------------
	// Two-entry buffer
	// ----------------------------------------
	logic [W-1:0] mem_q [2];
	logic [W-1:0] mem_d [2];
	logic [1:0]   cnt_q, cnt_d;
	logic         rd_q, rd_d, wr_q, wr_d;
	logic         push, pop;

	assign in_ready  = (cnt_q != 2'd2);
	assign out_valid = (cnt_q != 2'd0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		mem_d = mem_q;
		rd_d  = rd_q;
		wr_d  = wr_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wr_q] = in_data;
			wr_d        = !wr_q;
		end
		if (pop)
			rd_d = !rd_q;
		if (push && !pop)
			cnt_d = cnt_q + 2'd1;
		else if (pop && !push)
			cnt_d = cnt_q - 2'd1;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cnt_q <= 2'd0;
			rd_q  <= 1'b0;
			wr_q  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			rd_q  <= rd_d;
			wr_q  <= wr_d;
		end
		mem_q <= mem_d;
	end

endmodule

//--- sim/mdcp_core_assertions.sv
`timescale 1ns/1ns
module mdcp_core_assertions
	import mdcp_pkg::*;
#(
	parameter int RESERVE_CNT = RESERVE_CYCLES
) (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        rx_valid,
	input wire logic        rx_ready,
	input wire logic [7:0]  rx_data,
	input wire logic        tx_valid,
	input wire logic        tx_ready,
	input wire logic [7:0]  tx_data,
	input wire logic [9:0]  card_present,
	input wire logic        rail_collapse,
	input wire logic        latchup_sense,
	input wire logic        headroom_sample_valid,
	input wire logic [15:0] headroom_sample,
	input wire logic        chan_to_mid,
	input wire logic        bias_on_target,
	input wire logic        amps_shut_down,
	input wire logic [15:0] controller_condition_word,
	input wire logic [15:0] card_presence_word
);
	// ----
	// Length of the current collapse
	// ----
	logic [15:0] hold_q;
	logic [15:0] hold_d;
	always_comb begin
		hold_d = 16'h0000;
		if (rail_collapse && hold_q != 16'hFFFF)
			hold_d = hold_q + 16'h0001;
		else if (rail_collapse)
			hold_d = hold_q;
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			hold_q <= 16'h0000;
		else
			hold_q <= hold_d;
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_cmd_refuse: assert property (
		rx_valid && rx_ready |=> !rx_ready)
		else $error("second command taken before reply");
	a_nack_fast: assert property (
		rx_valid && rx_ready && rx_data[7] && !tx_valid
		|-> ##[1:4] (tx_valid && tx_data == RSP_NACK))
		else $error("no nack for eight-bit opcode");
	a_tx_hold: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("reply byte lost under stall");
	a_standby_mid: assert property (
		!bias_on_target |-> chan_to_mid)
		else $error("channels off midscale without bias");
	a_amps_bit: assert property (
		controller_condition_word[CW_AMPS_OFF] == amps_shut_down)
		else $error("shutdown bit disagrees");
	a_bad_sticky: assert property (
		controller_condition_word[CW_BAD_CMD]
		|=> controller_condition_word[CW_BAD_CMD])
		else $error("bad command flag cleared");
	a_latch_trip: assert property (
		$rose(latchup_sense) |-> ##[1:4] amps_shut_down)
		else $error("latch-up not shut down");
	a_collapse_trip: assert property (
		hold_q >= RESERVE_CNT + 6 |-> amps_shut_down)
		else $error("long collapse not shut down");
	a_presence_map: assert property (
		$stable(card_present)[*4]
		|-> card_presence_word == {card_present, 6'h00})
		else $error("presence word wrong");
	a_headroom_set: assert property (
		headroom_sample_valid && headroom_sample > HEADROOM_HI
		##1 !headroom_sample_valid
		|-> controller_condition_word[CW_HEADROOM])
		else $error("near rail flag missing");

	c_stall: cover property (tx_valid && !tx_ready);
	c_trip: cover property ($rose(amps_shut_down));
	c_bias_off: cover property ($fell(bias_on_target));
	c_volt: cover property (rx_valid && rx_ready && rx_data == CMD_VOLTAGE);
endmodule

//--- sim/mdcp_host.sv
`timescale 1ns/1ns
module mdcp_host (
	input  wire logic       ref_clk,
	input  wire logic       slow,
	output logic            rx_valid,
	input  wire logic       rx_ready,
	output logic      [7:0] rx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic [7:0] tx_data
);
	logic [7:0] got [0:1023];
	int         n = 0;

	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b1;
	end

	// Slow host drops ready every other cycle
	always @(negedge ref_clk) tx_ready <= slow ? ~tx_ready : 1'b1;

	always @(posedge ref_clk) begin
		if (tx_valid && tx_ready) begin
			got[n[9:0]] <= tx_data;
			n <= n + 1;
		end
	end

	task automatic send(input logic [7:0] b);
		int i;
		@(negedge ref_clk);
		rx_valid = 1'b1;
		rx_data = b;
		i = 0;
		while (!rx_ready && i < 50) begin
			@(negedge ref_clk);
			i++;
		end
		@(posedge ref_clk);
		@(negedge ref_clk);
		rx_valid = 1'b0;
		rx_data = ~b;
	endtask
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ns
module testbench
	import mdcp_pkg::*;
;
	localparam int          RES  = 20;
	localparam logic [39:0] FPOS = 40'hFD_CB98_6432;
	localparam logic [23:0] BAD  = 24'h7F_B041;
	logic        ref_clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
	logic        rx_valid, rx_ready, tx_valid, tx_ready, rd_req, rd_volt;
	logic        rd_ack = 1'b0, hsv = 1'b0, sag = 1'b0, coll = 1'b0;
	logic        latch = 1'b0, crd = 1'b0, brd = 1'b0;
	logic        fz, cmid, creq, breq, bon, amps;
	logic [7:0]  rx_data, tx_data, opt_sw = 8'h00, adr_sw = 8'h00;
	logic [8:0]  rd_index;
	logic [9:0]  cards = 10'h000, flags = 10'h000;
	logic [15:0] rd_word = 16'h0000, hs = 16'h8000, cw, pw;
	logic [15:0] hv [0:4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	int          fail_count = 0, compares = 0;

	always #5 ref_clk = ~ref_clk;

	mdcp_host host (.ref_clk(ref_clk), .slow(slow), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data));

	mdcp_core #(.RESERVE_CNT(RES)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.rd_req(rd_req), .rd_volt(rd_volt), .rd_index(rd_index),
		.rd_ack(rd_ack), .rd_word(rd_word), .card_present(cards),
		.bias_value(hv[0]), .aux_bias_value(hv[1]), .rail24_value(hv[2]),
		.backplane_temp(hv[3]), .fan_count(hv[4]),
		.option_switches(opt_sw), .address_switches(adr_sw),
		.input_port_live(flags[0]), .diagnostic_mode_flag(flags[1]),
		.factory_mode_flag(flags[2]), .reference_settled(flags[3]),
		.board_layout_fault(flags[4]), .rail_tolerance_flag(flags[5]),
		.too_hot_flag(flags[6]), .hardware_fault_flag(flags[7]),
		.cooling_loss_flag(flags[8]), .slew_idle_flag(flags[9]),
		.bias_sag_deep(sag), .rail_collapse(coll), .latchup_sense(latch),
		.headroom_sample_valid(hsv), .headroom_sample(hs),
		.frame_freeze(fz), .chan_ramp_req(creq), .chan_to_mid(cmid),
		.chan_ramp_done(crd), .bias_ramp_req(breq), .bias_on_target(bon),
		.bias_ramp_done(brd), .amps_shut_down(amps),
		.controller_condition_word(cw), .card_presence_word(pw));

	// ----
	// Table source and ramp stand-in
	// ----
	always @(negedge ref_clk) begin
		rd_ack <= rd_req & ~rd_ack;
		rd_word <= rd_req ? {rd_volt ? 4'hA : 4'h5, 3'b000, rd_index} : ~rd_word;
		crd <= creq;
		brd <= breq;
	end

	function automatic logic [15:0] wexp(input logic v, input logic [8:0] i);
		return {v ? 4'hA : 4'h5, 3'b000, i};
	endfunction
	function automatic logic [15:0] pk(input int i);
		return {host.got[2 * i + 2], host.got[2 * i + 1]};
	endfunction

	task automatic tally_and_finish();
		if (fail_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cmp_w(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_b(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic cmd(input logic [7:0] op, input int len);
		int i;
		host.n = 0;
		host.send(op);
		i = 0;
		while (host.n < len && i < 30000) begin
			@(negedge ref_clk);
			i++;
		end
		if (i >= 30000) begin
			fail_count++;
			$display("[FAIL] %0t reply timed out", $time);
			tally_and_finish();
		end
		repeat (10) @(negedge ref_clk);
		cmp_w(16'(host.n), 16'(len));
	endtask

	// ----
	// Scenarios
	// ----
	task automatic power(input logic [7:0] op, input logic on);
		cmd(op, 1);
		cmp_w(host.got[0], RSP_ACK);
		cmp_b(bon, on);
		cmp_b(cmid, ~on);
		cmp_b(fz, ~on);
		cmp_b(cw[CW_BIAS_ON], on);
	endtask
	task automatic t_nack();
		int i;
		for (i = 0; i < 3; i++) begin
			cmd(BAD[8 * i +: 8], 1);
			cmp_w(host.got[0], RSP_NACK);
			cmp_b(cw[CW_BAD_CMD], 1'b1);
			cmp_b(bon, 1'b0);
		end
	endtask
	task automatic t_volt();
		int s, c;
		logic [15:0] e;
		cards = 10'h205;
		slow = 1'b1;
		cmd(CMD_VOLTAGE, VOLT_PKT_BYTES);
		slow = 1'b0;
		cmp_w(host.got[0], CMD_VOLTAGE);
		for (s = 0; s < NUM_SLOTS; s++)
			for (c = 0; c < CHAN_PER_SLOT; c++) begin
				e = cards[s] ? wexp(1'b1, 9'(s * 48 + c)) : MIDSCALE;
				cmp_w(pk(s * 48 + c), e);
			end
	endtask
	task automatic t_status();
		int k;
		cards = 10'h3F0;
		opt_sw = 8'hA5;
		adr_sw = 8'h3C;
		for (k = 0; k < 5; k++)
			hv[k] = 16'(16'h0101 * (k + 3));
		cmd(CMD_STATUS, STAT_PKT_BYTES);
		cmp_w(host.got[0], CMD_STATUS);
		cmp_w(pk(0), 16'h0080);
		cmp_w(pk(1), {cards, 6'h00});
		cmp_w(pw, {cards, 6'h00});
		for (k = 0; k < 5; k++)
			cmp_w(pk(k + 2), hv[k]);
		cmp_w(pk(7), {adr_sw, opt_sw});
		for (k = 0; k < 140; k++)
			cmp_w(pk(k + 8), wexp(1'b0, 9'(k)));
	endtask
	task automatic t_flags();
		int i;
		for (i = 0; i < 10; i++) begin
			flags = 10'h001 << i;
			repeat (4) @(negedge ref_clk);
			cmp_b(cw[FPOS[4 * i +: 4]], 1'b1);
			flags = 10'h000;
			repeat (4) @(negedge ref_clk);
			cmp_b(cw[FPOS[4 * i +: 4]], 1'b0);
		end
	endtask
	task automatic head(input logic [15:0] s, input logic e);
		@(negedge ref_clk);
		hsv = 1'b1;
		hs = s;
		@(negedge ref_clk);
		hsv = 1'b0;
		hs = ~s;
		repeat (2) @(negedge ref_clk);
		cmp_b(cw[CW_HEADROOM], e);
	endtask
	task automatic trip(input int w, input int cyc, input logic e);
		@(negedge ref_clk);
		{latch, sag, coll} = 3'(3'b001 << w);
		repeat (cyc) @(negedge ref_clk);
		{latch, sag, coll} = 3'b000;
		repeat (4) @(negedge ref_clk);
		cmp_b(amps, e);
	endtask
	task automatic t_faults();
		trip(0, RES - 6, 1'b0);
		trip(0, RES + 10, 1'b1);
		cmp_b(cw[CW_AMPS_OFF], 1'b1);
		power(CMD_POWER_UP, 1'b1);
		cmp_b(amps, 1'b0);
		trip(1, RES + 10, 1'b1);
		power(CMD_POWER_UP, 1'b1);
		trip(2, 3, 1'b1);
	endtask

	initial begin
		repeat (6) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		power(CMD_POWER_DOWN, 1'b0);
		t_nack();
		power(CMD_POWER_UP, 1'b1);
		power(CMD_POWER_DOWN, 1'b0);
		t_volt();
		t_status();
		t_flags();
		head(16'hF000, 1'b1);
		head(16'h8000, 1'b0);
		head(16'h1000, 1'b1);
		head(16'h2000, 1'b0);
		t_faults();
		tally_and_finish();
	end
endmodule

bind mdcp_core mdcp_core_assertions #(.RESERVE_CNT(RESERVE_CNT)) chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .rx_valid(rx_valid),
	.rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .tx_data(tx_data), .card_present(card_present),
	.rail_collapse(rail_collapse), .latchup_sense(latchup_sense),
	.headroom_sample_valid(headroom_sample_valid),
	.headroom_sample(headroom_sample), .chan_to_mid(chan_to_mid),
	.bias_on_target(bias_on_target), .amps_shut_down(amps_shut_down),
	.controller_condition_word(controller_condition_word),
	.card_presence_word(card_presence_word));
